// ---- include/sdcct_cfg.svh ----
`ifndef SDCCT_CFG_SVH
`define SDCCT_CFG_SVH
`define SDCCT_REG_CTRL      5'h00
`define SDCCT_REG_STATUS    5'h04
`define SDCCT_REG_MODE0     5'h08
`define SDCCT_REG_MODE1     5'h0c
`define SDCCT_REG_MODE2     5'h10
`define SDCCT_REG_MODE3     5'h14
`define SDCCT_REG_RDCNT     5'h18
`define SDCCT_PAT_EN_BIT    2
`define SDCCT_CL_LSB        4
`define SDCCT_AL_LSB        3
`define SDCCT_BC4_MODE      2'h2
`define SDCCT_OTF_MODE      2'h1
`define SDCCT_OTF_BIT       12
`define SDCCT_AP_BIT        10
`define SDCCT_CHOP_BIT      2
`define SDCCT_LAT_LAST      2
`define SDCCT_PATTERN       8'haa
`define SDCCT_ZQ_LONG_CYC   512
`define SDCCT_ZQ_SHORT_CYC  64
`define SDCCT_CL_BASE       4
`define SDCCT_RESP_OKAY     2'h0
`define SDCCT_RESP_SLVERR   2'h2
`endif

// ---- include/sdcct_pkg.sv ----
package sdcct_pkg;
    typedef enum logic [2:0] {
        SDCCT_CMD_NOP  = 3'h0,
        SDCCT_CMD_MRS  = 3'h1,
        SDCCT_CMD_ACT  = 3'h2,
        SDCCT_CMD_RD   = 3'h3,
        SDCCT_CMD_PRE  = 3'h4,
        SDCCT_CMD_ZQL  = 3'h5,
        SDCCT_CMD_ZQS  = 3'h6,
        SDCCT_CMD_WR   = 3'h7
    } sdcct_cmd_t;
    typedef enum logic [1:0] {
        SDCCT_ST_IDLE  = 2'h0,
        SDCCT_ST_WAIT  = 2'h1,
        SDCCT_ST_BURST = 2'h2,
        SDCCT_ST_ZQ    = 2'h3
    } sdcct_state_t;
endpackage

// ---- hw/sdcct_core.sv ----
`timescale 1ns/100ps
`include "sdcct_cfg.svh"
module sdcct_core import sdcct_pkg::*; #(
    parameter int BANKS  = 8,
    parameter int DQ_W   = 8,
    parameter int ZQL_CYC = `SDCCT_ZQ_LONG_CYC
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic [2:0]        cmd,
    input  wire logic [2:0]        ba,
    input  wire logic [13:0]       addr,
    input  wire logic [2*DQ_W-1:0] array_rdata,
    output logic [2*DQ_W-1:0]      dq_rise_fall,
    output logic                   dq_valid,
    output logic                   dq_oe,
    output logic [BANKS-1:0]       row_open,
    output logic                   zq_busy,
    output logic                   pattern_mode,
    input  wire logic [4:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [4:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    initial begin
        if (BANKS < 1 || BANKS > 8 || DQ_W < 1 || ZQL_CYC < 2) begin
            $error("sdcct_core: bad parameter");
        end
    end

    logic [13:0] mode_q [4];
    logic [7:0]  ctrl_q;
    logic [31:0] rdcnt_q;
    sdcct_state_t st_q;
    logic [5:0]  lat_q;
    logic [15:0] zq_q;
    logic [2:0]  beat_q;
    logic [2:0]  beat_end_q;
    logic        ap_q;
    logic [2:0]  rd_bank_q;
    logic        use_pat_q;
    sdcct_state_t st_d;

    // decoded command strobes
    wire is_mrs  = cmd == SDCCT_CMD_MRS;
    wire is_act  = cmd == SDCCT_CMD_ACT;
    wire is_rd   = cmd == SDCCT_CMD_RD;
    wire is_pre  = cmd == SDCCT_CMD_PRE;
    wire is_zql  = cmd == SDCCT_CMD_ZQL;
    wire is_zqs  = cmd == SDCCT_CMD_ZQS;
    wire idle    = st_q == SDCCT_ST_IDLE;
    wire waiting = st_q == SDCCT_ST_WAIT;
    wire burst   = st_q == SDCCT_ST_BURST;
    wire zq_run  = st_q == SDCCT_ST_ZQ;
    wire pre_all = is_pre && addr[`SDCCT_AP_BIT];
    wire rd_cmd  = is_rd && idle;
    wire zq_cmd  = (is_zql || is_zqs) && idle;

    // read latency from mode fields
    wire [5:0] cl_w   = 6'(mode_q[0][`SDCCT_CL_LSB +: 3]) + 6'(`SDCCT_CL_BASE);
    wire [5:0] al_w   = (mode_q[1][`SDCCT_AL_LSB +: 2] == 2'h0) ? 6'h00 : 6'(cl_w - 6'(mode_q[1][`SDCCT_AL_LSB +: 2]));
    wire [5:0] rl_w   = 6'(al_w + cl_w);
    wire       pat_en = mode_q[3][`SDCCT_PAT_EN_BIT];
    wire [1:0] bl_w   = mode_q[0][1:0];
    wire       chop_w = (bl_w == `SDCCT_BC4_MODE) || (bl_w == `SDCCT_OTF_MODE && !addr[`SDCCT_OTF_BIT]);

    wire       upper_w = chop_w && addr[`SDCCT_CHOP_BIT];
    wire [2:0] first_w = upper_w ? 3'h4 : 3'h0;
    wire [2:0] last_w  = (chop_w && !upper_w) ? 3'h3 : 3'h7;
    wire       last_bt = burst && (3'(beat_q + 3'h1) == beat_end_q);
    wire       ap_done = last_bt && ap_q;

    function automatic logic bit_of_pattern(input logic [2:0] b);
        logic [7:0] pat;
        pat = `SDCCT_PATTERN;
        return pat[b];
    endfunction

    function automatic logic hits(input logic [2:0] sel, input int idx);
        return sel == 3'(idx);
    endfunction

    for (genvar m = 0; m < 4; m++) begin : g_mode
        wire load_m = is_mrs && hits(ba, m);
        always_ff @(posedge mclk) begin
            if (reset) begin
                mode_q[m] <= 14'h0000;
            end else if (load_m) begin
                mode_q[m] <= addr;
            end
        end
    end

    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        wire open_b  = is_act && hits(ba, b);
        wire close_b = (is_pre && (pre_all || hits(ba, b))) || (ap_done && hits(rd_bank_q, b));
        always_ff @(posedge mclk) begin
            if (reset) begin
                row_open[b] <= 1'b0;
            end else if (close_b) begin
                row_open[b] <= 1'b0;
            end else if (open_b) begin
                row_open[b] <= 1'b1;
            end
        end
    end

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SDCCT_ST_IDLE: begin
                if (rd_cmd) begin
                    st_d = SDCCT_ST_WAIT;
                end else if (zq_cmd) begin
                    st_d = SDCCT_ST_ZQ;
                end
            end
            SDCCT_ST_WAIT: begin
                if (lat_q <= 6'(`SDCCT_LAT_LAST)) st_d = SDCCT_ST_BURST;
            end
            SDCCT_ST_BURST: begin
                if (last_bt) st_d = SDCCT_ST_IDLE;
            end
            SDCCT_ST_ZQ: begin
                if (zq_q == 16'h0000) st_d = SDCCT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= SDCCT_ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            lat_q <= 6'h00;
        end else if (rd_cmd) begin
            lat_q <= rl_w;
        end else if (waiting) begin
            lat_q <= 6'(lat_q - 6'h1);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            zq_q <= 16'h0000;
        end else if (zq_cmd) begin
            zq_q <= is_zql ? 16'(ZQL_CYC - 1) : 16'(`SDCCT_ZQ_SHORT_CYC - 1);
        end else if (zq_run) begin
            zq_q <= 16'(zq_q - 16'h1);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            beat_q     <= 3'h0;
            beat_end_q <= 3'h0;
        end else if (rd_cmd) begin
            beat_q     <= first_w;
            beat_end_q <= last_w;
        end else if (burst) begin
            beat_q     <= 3'(beat_q + 3'h2);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ap_q      <= 1'b0;
            rd_bank_q <= 3'h0;
            use_pat_q <= 1'b0;
        end else if (rd_cmd) begin
            ap_q      <= addr[`SDCCT_AP_BIT];
            rd_bank_q <= ba;
            use_pat_q <= pat_en;
        end
    end

    // accepted reads, seen in the count register
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdcnt_q <= 32'h0;
        end else if (rd_cmd) begin
            rdcnt_q <= rdcnt_q + 32'h1;
        end
    end

    wire [DQ_W-1:0] pat_r = {DQ_W{bit_of_pattern(beat_q)}};
    wire [DQ_W-1:0] pat_f = {DQ_W{bit_of_pattern(3'(beat_q + 3'h1))}};

    always_ff @(posedge mclk) begin
        if (reset) begin
            dq_rise_fall <= '0;
            dq_valid     <= 1'b0;
        end else begin
            dq_valid     <= burst;
            dq_rise_fall <= !burst ? '0 : (use_pat_q ? {pat_f, pat_r} : array_rdata);
        end
    end
    assign dq_oe        = dq_valid;
    assign zq_busy      = zq_run;
    assign pattern_mode = pat_en;

    // axi4-lite slave
    logic aw_q, w_q;
    logic [4:0] awa_q;
    logic [31:0] wd_q;
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire aw_have = aw_q || s_axi_awvalid;
    wire w_have  = w_q || s_axi_wvalid;
    wire [4:0]  waddr = aw_q ? awa_q : s_axi_awaddr;
    wire [31:0] wdata = w_q ? wd_q : s_axi_wdata;
    wire do_wr = aw_have && w_have && !s_axi_bvalid;
    wire wr_ok = waddr == `SDCCT_REG_CTRL;

    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        unique case (s_axi_araddr)
            `SDCCT_REG_CTRL:   rd_mux = {24'h0, ctrl_q};
            `SDCCT_REG_STATUS: rd_mux = 32'({zq_busy, pat_en, st_q, row_open});
            `SDCCT_REG_MODE0:  rd_mux = {18'h0, mode_q[0]};
            `SDCCT_REG_MODE1:  rd_mux = {18'h0, mode_q[1]};
            `SDCCT_REG_MODE2:  rd_mux = {18'h0, mode_q[2]};
            `SDCCT_REG_MODE3:  rd_mux = {18'h0, mode_q[3]};
            `SDCCT_REG_RDCNT:  rd_mux = rdcnt_q;
            default: begin
                rd_mux = 32'h0;
                rd_ok  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 5'h00;
            wd_q <= 32'h0;
            ctrl_q <= 8'h00;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SDCCT_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SDCCT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `SDCCT_RESP_OKAY : `SDCCT_RESP_SLVERR;
                if (wr_ok && s_axi_wstrb[0]) ctrl_q <= wdata[7:0];
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `SDCCT_RESP_OKAY : `SDCCT_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // sdcct_core

// ---- verif/sdcct_core_props.sv ----
`timescale 1ns/100ps
module sdcct_core_props import sdcct_pkg::*; #(
    parameter int BANKS   = 8,
    parameter int DQ_W    = 8,
    parameter int ZQL_CYC = 512
) (
    input wire logic              mclk,
    input wire logic              reset,
    input wire logic [2:0]        cmd,
    input wire logic [2:0]        ba,
    input wire logic [13:0]       addr,
    input wire logic [2*DQ_W-1:0] dq_rise_fall,
    input wire logic              dq_valid,
    input wire logic              dq_oe,
    input wire logic [BANKS-1:0]  row_open,
    input wire logic              zq_busy,
    input wire logic              pattern_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [4:0] cl_q, cnt_q;
    logic [1:0] ac_q;
    logic [9:0] zc_q;
    logic       zl_q;
    wire logic [4:0] rl = (ac_q == 2'h0) ? cl_q : (cl_q << 1) - 5'(ac_q);
    always_ff @(posedge mclk) begin
        if (reset) begin
            cl_q <= 5'h04;
            ac_q <= 2'h0;
        end else if (cmd == SDCCT_CMD_MRS && ba == 3'h0) begin
            cl_q <= 5'(addr[6:4]) + 5'h04;
        end else if (cmd == SDCCT_CMD_MRS && ba == 3'h1) begin
            ac_q <= addr[4:3];
        end
    end
    // cycles left until a burst is due
    always_ff @(posedge mclk) begin
        if (reset) cnt_q <= 5'h00;
        else if (cmd == SDCCT_CMD_RD && cnt_q == 5'h00 && !dq_valid && !zq_busy) cnt_q <= rl;
        else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
    always_ff @(posedge mclk) begin
        if (reset || !zq_busy) zc_q <= 10'h000;
        else zc_q <= zc_q + 10'h001;
        if (reset) zl_q <= 1'b0;
        else if (!zq_busy && (cmd == SDCCT_CMD_ZQL || cmd == SDCCT_CMD_ZQS)) zl_q <= (cmd == SDCCT_CMD_ZQL);
    end
    pat_data_a: assert property (dq_valid && pattern_mode |-> !dq_rise_fall[0] && dq_rise_fall[DQ_W])
        else $error("pattern beat wrong");
    mode_pat_a: assert property (cmd == SDCCT_CMD_MRS && ba == 3'h3 |=> pattern_mode == $past(addr[2]))
        else $error("pattern enable not loaded");
    mode_keep_a: assert property (cmd != SDCCT_CMD_MRS || ba != 3'h3 |=> $stable(pattern_mode))
        else $error("pattern enable changed");
    read_lat_a: assert property (cnt_q == 5'h01 |-> !dq_valid ##1 dq_valid)
        else $error("burst start off");
    burst_len_a: assert property ($rose(dq_valid) |-> dq_valid[*2] ##1 (!dq_valid or dq_valid[*2] ##1 !dq_valid))
        else $error("burst length wrong");
    zq_len_a: assert property ($fell(zq_busy) |-> zc_q == (zl_q ? 10'(ZQL_CYC) : 10'h040))
        else $error("calibration length wrong");
    act_open_a: assert property (cmd == SDCCT_CMD_ACT |=> row_open[$past(ba)])
        else $error("row not opened");
    pre_all_a: assert property (cmd == SDCCT_CMD_PRE && addr[10] |=> row_open == '0)
        else $error("rows not closed");
    oe_match_a: assert property (dq_oe == dq_valid)
        else $error("drive enable off burst");
    cover property ($rose(dq_valid) && pattern_mode);
    cover property ($fell(zq_busy) && zl_q);
    cover property ($fell(row_open[3]));
endmodule // sdcct_core_props
bind sdcct_core sdcct_core_props #(.BANKS(BANKS), .DQ_W(DQ_W), .ZQL_CYC(ZQL_CYC)) i_sdcct_core_props (
    .mclk, .reset, .cmd, .ba, .addr, .dq_rise_fall, .dq_valid, .dq_oe, .row_open, .zq_busy, .pattern_mode);

// ---- verif/sdcct_ctrl_model.sv ----
`timescale 1ns/100ps
module sdcct_ctrl_model import sdcct_pkg::*; #(
    parameter int RP_CYC  = 3,
    parameter int MOD_CYC = 6
) (
    input  wire logic   mclk,
    output logic [2:0]  cmd,
    output logic [2:0]  ba,
    output logic [13:0] addr
);
    initial cmd = SDCCT_CMD_NOP;
    initial ba = 3'h0;
    initial addr = 14'h0000;
    task automatic issue(input sdcct_cmd_t c, input logic [2:0] b, input logic [13:0] a, input int gap);
        @(posedge mclk);
        cmd <= c;
        ba <= b;
        addr <= a;
        @(posedge mclk);
        cmd <= SDCCT_CMD_NOP;
        // released lines carry no stale value
        ba <= ~b;
        addr <= ~a;
        repeat (gap) @(posedge mclk);
    endtask
    task automatic load(input logic [2:0] b, input logic [13:0] a);
        issue(SDCCT_CMD_PRE, 3'h0, 14'h0400, RP_CYC);
        issue(SDCCT_CMD_MRS, b, a, MOD_CYC);
    endtask
endmodule // sdcct_ctrl_model

// ---- verif/tb_sdram_calib_cmd_timing.sv ----
`timescale 1ns/100ps
module tb_sdram_calib_cmd_timing import sdcct_pkg::*; ;
    typedef struct packed {logic [2:0] c; logic [1:0] a; logic h, s, p; logic [4:0] rl; logic [2:0] n;} sdcct_row_t;
    // cl code, al code, chop, a2, pattern, latency, burst clocks
    sdcct_row_t rows [6] = '{16'h0124, 16'h252a, 16'h4f5a, 16'h7064, 16'h8642, 16'hf1a4};
    sdcct_row_t r;
    logic mclk, reset = 1'b1, dq_valid, dq_oe, zq_busy, pattern_mode;
    logic [2:0] cmd, ba;
    logic [13:0] addr;
    logic [15:0] array_rdata = 16'h0000, dq_rise_fall;
    logic [7:0] row_open;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int bad_count = 0, tests_run = 0, cyc = 0, n;
    sdcct_core #(.ZQL_CYC(8)) i_sdcct_core (.mclk, .reset, .cmd, .ba, .addr, .array_rdata, .dq_rise_fall,
        .dq_valid, .dq_oe, .row_open, .zq_busy, .pattern_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sdcct_ctrl_model i_sdcct_ctrl_model (.mclk, .cmd, .ba, .addr);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic wrap_up;
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 10000) begin
            bad_count++;
            wrap_up;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic axr(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rresp", er, s_axi_rresp);
        chk("rdata", ed, s_axi_rdata);
    endtask
    task automatic rd_burst(input logic [2:0] b, input logic [13:0] a, input int rl, beats, input logic [15:0] m, e);
        int k;
        n = 0;
        k = 0;
        i_sdcct_ctrl_model.issue(SDCCT_CMD_RD, b, a, 0);
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (dq_valid !== 1'b1 && n < 40);
        chk("latency", rl, n);
        while (dq_valid === 1'b1 && k < 8) begin
            chk("beat", e, dq_rise_fall & m);
            k++;
            @(posedge mclk);
            #1;
        end
        chk("beats", beats, k);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        chk("reset", 32'h0, {pattern_mode, row_open, dq_valid, dq_oe, zq_busy});
        foreach (rows[i]) begin
            r = rows[i];
            array_rdata <= 16'h5a3c ^ 16'(i);
            i_sdcct_ctrl_model.load(3'h0, {7'h00, r.c, 4'h1});
            i_sdcct_ctrl_model.load(3'h1, {9'h000, r.a, 3'h0});
            i_sdcct_ctrl_model.load(3'h3, {11'h000, r.p, 2'h0});
            if (!r.p) i_sdcct_ctrl_model.issue(SDCCT_CMD_ACT, 3'h0, 14'h0000, 4);
            rd_burst(3'h0, {1'b0, ~r.h, 9'h000, r.s, 2'h0}, r.rl, r.n,
                r.p ? 16'h0101 : 16'hffff, r.p ? 16'h0100 : 16'h5a3c ^ 16'(i));
        end
        axr(5'h18, 32'h6, 2'h0);
        axr(5'h04, 32'h400, 2'h0);
        axr(5'h0c, 32'h10, 2'h0);
        axr(5'h14, 32'h04, 2'h0);
        axw(5'h00, 32'h1a5, 2'h0);
        axr(5'h00, 32'ha5, 2'h0);
        axw(5'h08, 32'h0, 2'h2);
        axr(5'h08, 32'h71, 2'h0);
        axr(5'h1c, 32'h0, 2'h2);
        i_sdcct_ctrl_model.load(3'h3, 14'h0000);
        i_sdcct_ctrl_model.issue(SDCCT_CMD_ACT, 3'h3, 14'h0000, 4);
        rd_burst(3'h3, 14'h1400, 20, 4, 16'hffff, 16'h5a39);
        chk("autopre", 32'h0, row_open);
        i_sdcct_ctrl_model.issue(SDCCT_CMD_ACT, 3'h5, 14'h0000, 4);
        rd_burst(3'h5, 14'h1000, 20, 4, 16'hffff, 16'h5a39);
        chk("kept", 32'h20, row_open);
        i_sdcct_ctrl_model.issue(SDCCT_CMD_RD, 3'h5, 14'h1000, 0);
        i_sdcct_ctrl_model.issue(SDCCT_CMD_RD, 3'h5, 14'h1000, 0);
        n = 0;
        repeat (40) begin
            @(posedge mclk);
            #1;
            if (dq_valid === 1'b1) n++;
        end
        chk("refused", 4, n);
        i_sdcct_ctrl_model.issue(SDCCT_CMD_PRE, 3'h0, 14'h0400, 3);
        for (int z = 0; z < 2; z++) begin
            i_sdcct_ctrl_model.issue(z ? SDCCT_CMD_ZQS : SDCCT_CMD_ZQL, 3'h0, 14'h0000, 0);
            n = 0;
            #1;
            while (zq_busy === 1'b1 && n < 100) begin
                n++;
                @(posedge mclk);
                #1;
            end
            chk("zq", z ? 64 : 8, n);
        end
        i_sdcct_ctrl_model.issue(SDCCT_CMD_ACT, 3'h2, 14'h0000, 0);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        chk("rerun", 32'h0, {pattern_mode, row_open, dq_valid, dq_oe, zq_busy});
        wrap_up;
    end
endmodule // tb_sdram_calib_cmd_timing
